/* hw/pmr_pkg.sv */
/*
 Shared constants, types and decode functions for the power-module
 command-code register bank.
 Assumes a single 20 MHz core clock and an active-low asynchronous reset.
*/
`default_nettype none

package pmr_pkg;

   // Core clock
   localparam int unsigned PMR_CLK_HZ = 20_000_000;

   // Command codes of the bank
   localparam logic [7:0] PMR_CODE_VOUT_FORMAT    = 8'h20;
   localparam logic [7:0] PMR_CODE_OT_FAULT       = 8'h4f;
   localparam logic [7:0] PMR_CODE_OT_ACTION      = 8'h50;
   localparam logic [7:0] PMR_CODE_OT_WARN        = 8'h51;
   localparam logic [7:0] PMR_CODE_UT_WARN        = 8'h52;
   localparam logic [7:0] PMR_CODE_UT_FAULT       = 8'h53;
   localparam logic [7:0] PMR_CODE_UT_ACTION      = 8'h54;
   localparam logic [7:0] PMR_CODE_VIN_HI_FAULT   = 8'h55;
   localparam logic [7:0] PMR_CODE_VIN_HI_ACTION  = 8'h56;
   localparam logic [7:0] PMR_CODE_VIN_HI_WARN    = 8'h57;
   localparam logic [7:0] PMR_CODE_VIN_LO_WARN    = 8'h58;
   localparam logic [7:0] PMR_CODE_VIN_LO_FAULT   = 8'h59;
   localparam logic [7:0] PMR_CODE_VIN_LO_ACTION  = 8'h5a;
   localparam logic [7:0] PMR_CODE_PG_THRESHOLD   = 8'h5e;
   localparam logic [7:0] PMR_CODE_TON_WAIT       = 8'h60;
   localparam logic [7:0] PMR_CODE_TON_RAMP       = 8'h61;
   localparam logic [7:0] PMR_CODE_TOFF_WAIT      = 8'h64;
   localparam logic [7:0] PMR_CODE_TOFF_RAMP      = 8'h65;
   localparam logic [7:0] PMR_CODE_SUMMARY_SHORT  = 8'h78;
   localparam logic [7:0] PMR_CODE_SUMMARY_LONG   = 8'h79;
   localparam logic [7:0] PMR_CODE_VOUT_FLAGS     = 8'h7a;
   localparam logic [7:0] PMR_CODE_IOUT_FLAGS     = 8'h7b;
   localparam logic [7:0] PMR_CODE_INPUT_FLAGS    = 8'h7c;
   localparam logic [7:0] PMR_CODE_TEMP_FLAGS     = 8'h7d;
   localparam logic [7:0] PMR_CODE_CML_FLAGS      = 8'h7e;
   localparam logic [7:0] PMR_CODE_MONITOR_FLAGS  = 8'h80;
   localparam logic [7:0] PMR_CODE_VIN_READING    = 8'h88;
   localparam logic [7:0] PMR_CODE_VOUT_READING   = 8'h8b;
   localparam logic [7:0] PMR_CODE_IOUT_READING   = 8'h8c;
   localparam logic [7:0] PMR_CODE_TEMP_READING   = 8'h8d;
   localparam logic [7:0] PMR_CODE_DUTY_READING   = 8'h94;
   localparam logic [7:0] PMR_CODE_RATE_READING   = 8'h95;

   // Linear mode, exponent -13
   localparam logic [7:0] PMR_VOUT_FORMAT_VALUE = 8'h13;

   // Word register storage: index order
   localparam int unsigned PMR_NUM_WORDS = 13;
   localparam logic [3:0] PMR_IDX_OT_FAULT     = 4'h0;
   localparam logic [3:0] PMR_IDX_OT_WARN      = 4'h1;
   localparam logic [3:0] PMR_IDX_UT_WARN      = 4'h2;
   localparam logic [3:0] PMR_IDX_UT_FAULT     = 4'h3;
   localparam logic [3:0] PMR_IDX_VIN_HI_FAULT = 4'h4;
   localparam logic [3:0] PMR_IDX_VIN_HI_WARN  = 4'h5;
   localparam logic [3:0] PMR_IDX_VIN_LO_WARN  = 4'h6;
   localparam logic [3:0] PMR_IDX_VIN_LO_FAULT = 4'h7;
   localparam logic [3:0] PMR_IDX_PG           = 4'h8;
   localparam logic [3:0] PMR_IDX_TON_WAIT     = 4'h9;
   localparam logic [3:0] PMR_IDX_TON_RAMP     = 4'ha;
   localparam logic [3:0] PMR_IDX_TOFF_WAIT    = 4'hb;
   localparam logic [3:0] PMR_IDX_TOFF_RAMP    = 4'hc;
   localparam logic [3:0] PMR_IDX_NONE         = 4'hf;

   // Index 12 first; the power-good slot is loaded from the strap after reset
   localparam logic [12:0][15:0] PMR_WORD_RESET = {
      16'hd280, 16'hca80, 16'hd280, 16'hca80, 16'h0000, 16'hca00, 16'hca30,
      16'hd34d, 16'hd3a0, 16'he490, 16'he4e0, 16'heb70, 16'hebe8};

   // Fault-action bytes: 0 overheat, 1 cold, 2 input high, 3 input low
   localparam int unsigned PMR_NUM_BYTES = 4;
   localparam logic [2:0] PMR_BIDX_NONE = 3'h7;
   localparam logic [7:0] PMR_ACTION_RESET = 8'h80;
   localparam logic [7:0] PMR_FLAGS_RESET = 8'h00;

   // Comm/memory/logic flag bits raised by refused transactions
   localparam int unsigned PMR_CML_BAD_CODE = 7;
   localparam int unsigned PMR_CML_BAD_DATA = 6;

   // Summary bit positions
   localparam int unsigned PMR_SUM_VOUT_OV = 5;
   localparam int unsigned PMR_SUM_IOUT_OC = 4;
   localparam int unsigned PMR_SUM_VIN_UV  = 3;
   localparam int unsigned PMR_SUM_TEMP    = 2;
   localparam int unsigned PMR_SUM_CML     = 1;
   localparam int unsigned PMR_SUM_OTHER   = 0;
   localparam int unsigned PMR_INPUT_UV_BIT = 4;

   // Edges after reset release before the strap is trusted
   localparam logic [1:0] PMR_INIT_SYNC_CYCLES = 2'd2;

   // Power-good default is 0.9 of the strap: 922/1024
   localparam logic [25:0] PMR_PG_NUM = 26'd922;

   typedef enum logic [1:0] {
      PMR_INIT_WAIT = 2'b00,
      PMR_INIT_LOAD = 2'b01,
      PMR_READY     = 2'b10
   } pmr_init_t;

   typedef struct packed {
      logic        write;
      logic        is_word;
      logic [7:0]  code;
      logic [15:0] data;
   } pmr_req_t;

   typedef struct packed {
      logic        ack;
      logic [15:0] data;
   } pmr_rsp_t;

   typedef struct packed {
      logic [7:0] vout;
      logic [7:0] iout;
      logic [7:0] input_side;
      logic [7:0] temp;
      logic [7:0] cml;
      logic [7:0] monitor;
   } pmr_flags_t;

   typedef struct packed {
      logic [15:0] vin;
      logic [15:0] vout;
      logic [15:0] iout;
      logic [15:0] temp;
      logic [15:0] duty;
      logic [15:0] rate;
   } pmr_telemetry_t;

   function automatic logic [3:0] pmr_word_index(input logic [7:0] code);
      case (code)
         PMR_CODE_OT_FAULT:     return PMR_IDX_OT_FAULT;
         PMR_CODE_OT_WARN:      return PMR_IDX_OT_WARN;
         PMR_CODE_UT_WARN:      return PMR_IDX_UT_WARN;
         PMR_CODE_UT_FAULT:     return PMR_IDX_UT_FAULT;
         PMR_CODE_VIN_HI_FAULT: return PMR_IDX_VIN_HI_FAULT;
         PMR_CODE_VIN_HI_WARN:  return PMR_IDX_VIN_HI_WARN;
         PMR_CODE_VIN_LO_WARN:  return PMR_IDX_VIN_LO_WARN;
         PMR_CODE_VIN_LO_FAULT: return PMR_IDX_VIN_LO_FAULT;
         PMR_CODE_PG_THRESHOLD: return PMR_IDX_PG;
         PMR_CODE_TON_WAIT:     return PMR_IDX_TON_WAIT;
         PMR_CODE_TON_RAMP:     return PMR_IDX_TON_RAMP;
         PMR_CODE_TOFF_WAIT:    return PMR_IDX_TOFF_WAIT;
         PMR_CODE_TOFF_RAMP:    return PMR_IDX_TOFF_RAMP;
         default:               return PMR_IDX_NONE;
      endcase
   endfunction

   function automatic logic [2:0] pmr_byte_index(input logic [7:0] code);
      case (code)
         PMR_CODE_OT_ACTION:     return 3'h0;
         PMR_CODE_UT_ACTION:     return 3'h1;
         PMR_CODE_VIN_HI_ACTION: return 3'h2;
         PMR_CODE_VIN_LO_ACTION: return 3'h3;
         default:                return PMR_BIDX_NONE;
      endcase
   endfunction

   function automatic logic [15:0] pmr_pg_default(input logic [15:0] strap);
      logic [25:0] prod;
      prod = {10'h000, strap} * PMR_PG_NUM;
      return prod[25:10];
   endfunction

endpackage

`default_nettype wire

/* hw/pmr_status_flags.sv */
/*
 Sticky category status bytes of the register bank.
 Assumes set pulses come from logic on core_clk; clear_faults is a
 one-cycle pulse from the same domain.
*/
`default_nettype none

module pmr_status_flags
   import pmr_pkg::*;
(
   // Clock and reset
   input  wire logic           core_clk,
   input  wire logic           rst_n,
   // Event sources
   input  wire pmr_pkg::pmr_flags_t set_events,
   input  wire logic [7:0]     cml_set,
   input  wire logic           clear_faults,
   // Held flags
   output var  pmr_pkg::pmr_flags_t flags
);
   import pmr_pkg::*;

   pmr_flags_t set_all;
   pmr_flags_t flags_reg;

   always_comb begin
      set_all     = set_events;
      set_all.cml = set_events.cml | cml_set;
   end

   // A set arriving with the clear survives it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= {6{PMR_FLAGS_RESET}};
      end else if (clear_faults) begin
         flags_reg <= set_all;
      end else begin
         flags_reg <= flags_reg | set_all;
      end
   end

   assign flags = flags_reg;

   a_set_wins_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      (clear_faults && set_all.temp[0]) |=> flags_reg.temp[0])
      else $error("status set lost against a clear");

endmodule

`default_nettype wire

/* hw/pmr_limit_status_map.sv */
/*
 Command-code register bank of a step-down power module: limits, fault
 actions, power-good threshold, sequencing times, status and telemetry.
 Assumes a PMBus framing layer on core_clk hands over one decoded
 transaction per req_valid and accepts one response per rsp_valid.
*/
// Contract
// - Code 4Fh: read/write overheat fault word, reset EBE8h.
// - Fault-action bytes 50h, 54h, 56h, 5Ah read/write, reset 80h.
// - Code 51h: read/write overheat warning word, reset EB70h.
// - Code 52h: read/write cold warning word, reset E4E0h.
// - Code 53h: read/write cold fault word, reset E490h.
// - Code 55h: read/write input high fault word, reset D3A0h.
// - Code 57h: read/write input high warning word, reset D34Dh.
// - Input low warning 58h resets CA30h, fault 59h resets CA00h.
// - Code 5Eh: read/write power-good word, default 0.9 of strapped output.
// - Code 60h: read/write turn-on wait word, reset CA80h.
// - Code 61h: read/write turn-on ramp word, reset D280h.
// - Code 64h: read/write turn-off wait word, reset CA80h.
// - Code 65h: read/write turn-off ramp word, reset D280h.
// - Code 78h read as byte gives short fault summary, 00h after reset.
// - Code 79h read as word gives long fault summary, 0000h after reset.
// - Category status bytes 7Ah-7Eh and 80h are read-only, reset 00h.
// - Input voltage word at 88h, output voltage word at 8Bh, read-only.
// - Current 8Ch, temperature 8Dh, duty 94h, frequency 95h read-only words.
// - Output voltage format byte reads 13h: linear, exponent -13.
`default_nettype none

module pmr_limit_status_map
   import pmr_pkg::*;
(
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // Transaction request
   input  wire logic                  req_valid,
   input  wire pmr_pkg::pmr_req_t     req,
   output logic                       req_ready,
   // Transaction response
   output logic                       rsp_valid,
   output pmr_pkg::pmr_rsp_t          rsp,
   // Fault sources and clearing
   input  wire pmr_pkg::pmr_flags_t   fault_events,
   input  wire logic                  clear_faults,
   // Measurements and strap
   input  wire pmr_pkg::pmr_telemetry_t telemetry,
   input  wire logic [15:0]           vout_strap,
   // Configuration toward the power stage
   output logic [12:0][15:0]          limit_words,
   output logic [3:0][7:0]            action_bytes,
   output logic                       power_good
);
   import pmr_pkg::*;

   pmr_init_t       init_state_reg;
   logic [1:0]      init_cnt_reg;
   logic [15:0]     strap_meta_reg;
   logic [15:0]     strap_sync_reg;
   logic            req_ready_reg;
   logic            rsp_valid_reg;
   pmr_rsp_t        rsp_reg;
   logic [12:0][15:0] words_reg;
   logic [3:0][7:0] bytes_reg;
   pmr_telemetry_t  telemetry_reg;
   logic            power_good_reg;
   pmr_flags_t      flags;
   logic [7:0]      summary_short;
   logic [15:0]     summary_long;
   logic [3:0]      widx;
   logic [2:0]      bidx;
   logic            rd_known;
   logic            rd_word;
   logic            rd_ro;
   logic [15:0]     rd_data;
   logic            take;
   logic            ok;
   logic [7:0]      cml_set;

   // Strap is a static pin level; synchronised before use
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_meta_reg <= 16'h0000;
         strap_sync_reg <= 16'h0000;
      end else begin
         strap_meta_reg <= vout_strap;
         strap_sync_reg <= strap_meta_reg;
      end
   end

   // Start-up: wait for the strap, load the power-good default, then serve
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_state_reg <= PMR_INIT_WAIT;
         init_cnt_reg   <= 2'd0;
      end else begin
         case (init_state_reg)
            PMR_INIT_WAIT: begin
               if (init_cnt_reg == PMR_INIT_SYNC_CYCLES) begin
                  init_state_reg <= PMR_INIT_LOAD;
               end else begin
                  init_cnt_reg <= init_cnt_reg + 2'd1;
               end
            end
            PMR_INIT_LOAD: begin
               init_state_reg <= PMR_READY;
            end
            PMR_READY: begin
               init_state_reg <= PMR_READY;
            end
            default: begin
               init_state_reg <= PMR_INIT_WAIT;
            end
         endcase
      end
   end

   // Nothing is accepted until every default is in place
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_ready_reg <= 1'b0;
      end else begin
         req_ready_reg <= (init_state_reg != PMR_INIT_WAIT);
      end
   end

   assign take = req_valid && req_ready_reg;

   // Summaries are derived from held flags, so they clear with them
   always_comb begin
      summary_short = 8'h00;
      summary_short[PMR_SUM_VOUT_OV] = flags.vout[7];
      summary_short[PMR_SUM_IOUT_OC] = flags.iout[7];
      summary_short[PMR_SUM_VIN_UV]  = flags.input_side[PMR_INPUT_UV_BIT];
      summary_short[PMR_SUM_TEMP]    = |flags.temp;
      summary_short[PMR_SUM_CML]     = |flags.cml;
      summary_short[PMR_SUM_OTHER]   = |flags.monitor;
      summary_long = {|flags.vout, |flags.iout, |flags.input_side, |flags.monitor,
                      4'h0, summary_short};
   end

   // Read and access decode
   always_comb begin
      widx     = pmr_word_index(req.code);
      bidx     = pmr_byte_index(req.code);
      rd_known = 1'b1;
      rd_word  = 1'b1;
      rd_ro    = 1'b1;
      rd_data  = 16'h0000;
      if (widx != PMR_IDX_NONE) begin
         rd_ro   = 1'b0;
         rd_data = words_reg[widx];
      end else if (bidx != PMR_BIDX_NONE) begin
         rd_ro   = 1'b0;
         rd_word = 1'b0;
         rd_data = {8'h00, bytes_reg[bidx]};
      end else begin
         case (req.code)
            PMR_CODE_VOUT_FORMAT: begin
               rd_word = 1'b0;
               rd_data = {8'h00, PMR_VOUT_FORMAT_VALUE};
            end
            PMR_CODE_SUMMARY_SHORT: begin
               rd_word = 1'b0;
               rd_data = {8'h00, summary_short};
            end
            PMR_CODE_SUMMARY_LONG:  rd_data = summary_long;
            PMR_CODE_VOUT_FLAGS: begin
               rd_word = 1'b0;
               rd_data = {8'h00, flags.vout};
            end
            PMR_CODE_IOUT_FLAGS: begin
               rd_word = 1'b0;
               rd_data = {8'h00, flags.iout};
            end
            PMR_CODE_INPUT_FLAGS: begin
               rd_word = 1'b0;
               rd_data = {8'h00, flags.input_side};
            end
            PMR_CODE_TEMP_FLAGS: begin
               rd_word = 1'b0;
               rd_data = {8'h00, flags.temp};
            end
            PMR_CODE_CML_FLAGS: begin
               rd_word = 1'b0;
               rd_data = {8'h00, flags.cml};
            end
            PMR_CODE_MONITOR_FLAGS: begin
               rd_word = 1'b0;
               rd_data = {8'h00, flags.monitor};
            end
            PMR_CODE_VIN_READING:  rd_data = telemetry_reg.vin;
            PMR_CODE_VOUT_READING: rd_data = telemetry_reg.vout;
            PMR_CODE_IOUT_READING: rd_data = telemetry_reg.iout;
            PMR_CODE_TEMP_READING: rd_data = telemetry_reg.temp;
            PMR_CODE_DUTY_READING: rd_data = telemetry_reg.duty;
            PMR_CODE_RATE_READING: rd_data = telemetry_reg.rate;
            default: begin
               rd_known = 1'b0;
            end
         endcase
      end
   end

   // A wrong transfer size or a write to a read-only code is refused
   assign ok = rd_known && (req.is_word == rd_word) && !(req.write && rd_ro);

   always_comb begin
      cml_set = 8'h00;
      cml_set[PMR_CML_BAD_CODE] = take && !rd_known;
      cml_set[PMR_CML_BAD_DATA] = take && rd_known && !ok;
   end

   // Response is answered one edge after acceptance
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid_reg <= 1'b0;
         rsp_reg       <= '0;
      end else begin
         rsp_valid_reg <= take;
         if (take) begin
            rsp_reg.ack  <= ok;
            rsp_reg.data <= (ok && !req.write) ? rd_data : 16'h0000;
         end
      end
   end

   // Limit and timing words; power-good slot loaded once from the strap
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         words_reg <= PMR_WORD_RESET;
      end else if (init_state_reg == PMR_INIT_LOAD) begin
         words_reg[PMR_IDX_PG] <= pmr_pg_default(strap_sync_reg);
      end else if (take && ok && req.write && (widx != PMR_IDX_NONE)) begin
         words_reg[widx] <= req.data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bytes_reg <= {PMR_NUM_BYTES{PMR_ACTION_RESET}};
      end else if (take && ok && req.write && (bidx != PMR_BIDX_NONE)) begin
         bytes_reg[bidx] <= req.data[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         telemetry_reg <= '0;
      end else begin
         telemetry_reg <= telemetry;
      end
   end

   // Both words share the exponent, so a plain unsigned compare suffices
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_good_reg <= 1'b0;
      end else begin
         power_good_reg <= req_ready_reg && (telemetry_reg.vout >= words_reg[PMR_IDX_PG]);
      end
   end

   pmr_status_flags u_flags (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .set_events   (fault_events),
      .cml_set      (cml_set),
      .clear_faults (clear_faults),
      .flags        (flags)
   );

   assign req_ready    = req_ready_reg;
   assign rsp_valid    = rsp_valid_reg;
   assign rsp          = rsp_reg;
   assign limit_words  = words_reg;
   assign action_bytes = bytes_reg;
   assign power_good   = power_good_reg;

   a_ot_fault_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      (init_state_reg == PMR_INIT_WAIT) |-> (words_reg[PMR_IDX_OT_FAULT] == 16'hebe8))
      else $error("overheat fault word not at its default");

   a_action_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      (init_state_reg == PMR_INIT_WAIT) |-> (bytes_reg == {4{8'h80}}))
      else $error("fault action bytes not at their default");

   a_limit_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
      (init_state_reg == PMR_INIT_WAIT) |->
      (words_reg[PMR_IDX_OT_WARN] == 16'heb70) && (words_reg[PMR_IDX_UT_FAULT] == 16'he490)
      && (words_reg[PMR_IDX_VIN_LO_WARN] == 16'hca30)
      && (words_reg[PMR_IDX_VIN_LO_FAULT] == 16'hca00))
      else $error("limit word not at its default");

   a_timing_resets: assert property (@(posedge core_clk) disable iff (!rst_n)
      (init_state_reg == PMR_INIT_WAIT) |->
      (words_reg[PMR_IDX_TON_WAIT] == 16'hca80) && (words_reg[PMR_IDX_TOFF_RAMP] == 16'hd280))
      else $error("sequencing word not at its default");

   a_pg_load: assert property (@(posedge core_clk) disable iff (!rst_n)
      (init_state_reg == PMR_INIT_LOAD) |=>
      (words_reg[PMR_IDX_PG] == pmr_pg_default($past(strap_sync_reg))) && req_ready_reg)
      else $error("power-good default not loaded from strap");

   a_ready_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(req_ready_reg) |-> ($past(init_state_reg) == PMR_INIT_LOAD))
      else $error("requests accepted before defaults loaded");

   a_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
      (take && req.write && req.is_word && req.code == PMR_CODE_OT_FAULT) |=>
      rsp_valid_reg && rsp_reg.ack && (words_reg[PMR_IDX_OT_FAULT] == $past(req.data)))
      else $error("word write did not land");

   a_ro_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
      (take && req.write && req.code == PMR_CODE_TEMP_FLAGS) |=>
      !rsp_reg.ack ##1 flags.cml[PMR_CML_BAD_DATA])
      else $error("write to read-only code not refused");

   a_short_summary: assert property (@(posedge core_clk) disable iff (!rst_n)
      (take && !req.write && !req.is_word && req.code == PMR_CODE_SUMMARY_SHORT) |=>
      rsp_reg.ack && (rsp_reg.data == {8'h00, $past(summary_short)}))
      else $error("short summary read mismatch");

   a_vin_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      (take && !req.write && req.is_word && req.code == PMR_CODE_VIN_READING) |=>
      rsp_reg.ack && (rsp_reg.data == $past(telemetry_reg.vin)))
      else $error("input voltage read mismatch");

   a_format_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      (take && !req.write && !req.is_word && req.code == PMR_CODE_VOUT_FORMAT) |=>
      rsp_reg.ack && (rsp_reg.data == 16'h0013))
      else $error("output voltage format read mismatch");

   c_summary_read: cover property (@(posedge core_clk) disable iff (!rst_n)
      take && !req.write && req.code == PMR_CODE_SUMMARY_LONG);
   c_limit_write: cover property (@(posedge core_clk) disable iff (!rst_n)
      take && req.write && req.code == PMR_CODE_TON_WAIT);
   c_refused: cover property (@(posedge core_clk) disable iff (!rst_n)
      rsp_valid_reg && !rsp_reg.ack);

endmodule

`default_nettype wire

/* dv/pmr_host_model.sv */
/* Host model that issues one decoded transaction at a time to the bank.
   Assumes the bank answers one cycle after it takes a request. */
`default_nettype none
module pmr_host_model
   import pmr_pkg::*;
(
   // Clock
   input  wire logic              core_clk,
   // Bank side
   input  wire logic              req_ready,
   input  wire logic              rsp_valid,
   input  wire pmr_pkg::pmr_rsp_t rsp,
   output var  logic              req_valid,
   output var  pmr_pkg::pmr_req_t req,
   output var  logic              hung
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req_valid = 1'b0;
      req = '0;
      hung = 1'b0;
   end
   // Size and direction come from the caller; wrong sizes and read-only writes are sent only when a test asks
   task automatic xfer(input pmr_req_t r, output pmr_rsp_t g);
      int n;
      n = 0;
      @(negedge core_clk);
      req_valid = 1'b1;
      req = r;
      while (!req_ready && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      g = rsp;
      hung = !rsp_valid;
      req_valid = 1'b0;
      // Scrambled once released so the bank cannot lean on stale bits
      req = ~r;
   endtask
endmodule
`default_nettype wire

/* dv/pmr_limit_status_map_tb.sv */
/* Bench for the register bank: reads and writes through the host model.
   Assumes constant telemetry and strap inputs. */
`default_nettype none
module pmr_limit_status_map_tb
   import pmr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic     core_clk, rst_n, req_valid, req_ready, rsp_valid, hung;
   pmr_req_t req;
   pmr_rsp_t rsp, got;
   int       bad_count, compares;
   pmr_flags_t        fev;
   logic              clr, pg;
   logic [12:0][15:0] lw;
   logic [3:0][7:0]   ab;
   pmr_limit_status_map uut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .fault_events(fev), .clear_faults(clr), .vout_strap(16'h2000),
      .telemetry({16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666}),
      .limit_words(lw), .action_bytes(ab), .power_good(pg));
   pmr_host_model host (.core_clk(core_clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp(rsp), .req_valid(req_valid), .req(req), .hung(hung));
   task automatic chk(input pmr_rsp_t g, input pmr_rsp_t e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_out(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t out %h exp %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic w, input logic [7:0] c, input logic [16:0] e);
      host.xfer({1'b0, w, c, 16'h0000}, got);
      chk(got, e);
   endtask
   // Default first, then a written pattern must read back
   task automatic rw(input logic w, input logic [7:0] c, input logic [15:0] d);
      rd(w, c, {1'b1, d});
      host.xfer({1'b1, w, c, w ? 16'h5aa5 : 16'h00a5}, got);
      chk(got, 17'h10000);
      rd(w, c, {1'b1, w ? 16'h5aa5 : 16'h00a5});
   endtask
   task automatic stop_test();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge hung) begin
      bad_count++;
      stop_test();
   end
   initial begin
      rst_n = 1'b0;
      bad_count = 0;
      compares = 0;
      fev = '0;
      clr = 1'b0;
      repeat (10) @(negedge core_clk);
      rst_n = 1'b1;
      rd(1'b0, 8'h78, 17'h10000);
      chk_out({15'h0000, pg}, 16'h0001);
      chk_out({8'h00, ab[0]}, 16'h0080);
      rd(1'b1, 8'h79, 17'h10000);
      rw(1'b1, 8'h4f, 16'hebe8);
      rw(1'b0, 8'h50, 16'h0080);
      rw(1'b0, 8'h54, 16'h0080);
      rw(1'b0, 8'h56, 16'h0080);
      rw(1'b0, 8'h5a, 16'h0080);
      rw(1'b1, 8'h51, 16'heb70);
      rw(1'b1, 8'h52, 16'he4e0);
      rw(1'b1, 8'h53, 16'he490);
      rw(1'b1, 8'h55, 16'hd3a0);
      rw(1'b1, 8'h57, 16'hd34d);
      rw(1'b1, 8'h58, 16'hca30);
      rw(1'b1, 8'h59, 16'hca00);
      rw(1'b1, 8'h5e, 16'h1cd0);
      rw(1'b1, 8'h60, 16'hca80);
      rw(1'b1, 8'h61, 16'hd280);
      rw(1'b1, 8'h64, 16'hca80);
      rw(1'b1, 8'h65, 16'hd280);
      chk_out(lw[0], 16'h5aa5);
      chk_out({8'h00, ab[3]}, 16'h00a5);
      // Threshold now above the reading, so power-good must drop
      chk_out({15'h0000, pg}, 16'h0000);
      rd(1'b0, 8'h20, 17'h10013);
      rd(1'b1, 8'h88, 17'h11111);
      rd(1'b1, 8'h8b, 17'h12222);
      rd(1'b1, 8'h8c, 17'h13333);
      rd(1'b1, 8'h8d, 17'h14444);
      rd(1'b1, 8'h94, 17'h15555);
      rd(1'b1, 8'h95, 17'h16666);
      for (int i = 8'h7a; i <= 8'h80; i++) if (i != 8'h7f) rd(1'b0, 8'(i), 17'h10000);
      // A refused write to a status byte leaves a bad-data flag behind
      host.xfer({1'b1, 1'b0, 8'h7d, 16'h00ff}, got);
      chk(got, 17'h00000);
      rd(1'b1, 8'h7f, 17'h00000);
      rd(1'b1, 8'h50, 17'h00000);
      rd(1'b0, 8'h7e, 17'h100c0);
      rd(1'b0, 8'h78, 17'h10002);
      rd(1'b1, 8'h79, 17'h10002);
      // Set and clear in one cycle: the set must survive the clear
      @(negedge core_clk);
      fev.temp = 8'h01;
      clr = 1'b1;
      @(negedge core_clk);
      fev = {8'h80, 8'h80, 8'h10, 8'h00, 8'h00, 8'h01};
      clr = 1'b0;
      @(negedge core_clk);
      fev = '0;
      rd(1'b0, 8'h7d, 17'h10001);
      rd(1'b0, 8'h7e, 17'h10000);
      rd(1'b0, 8'h7c, 17'h10010);
      rd(1'b0, 8'h78, 17'h1003d);
      rd(1'b1, 8'h79, 17'h1f03d);
      rst_n = 1'b0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      rd(1'b1, 8'h4f, 17'h1ebe8);
      rd(1'b0, 8'h50, 17'h10080);
      rd(1'b1, 8'h5e, 17'h11cd0);
      rd(1'b0, 8'h7d, 17'h10000);
      chk_out(lw[0], 16'hebe8);
      chk_out({15'h0000, pg}, 16'h0001);
      stop_test();
   end
endmodule
`default_nettype wire
